// >>> src/cmsf_flag_bank.sv
/*
  Message-object status flag bank: pending-transmit, fresh-payload and
  object interrupt flags for 32 objects, with an AHB-Lite read view,
  an interrupt identifier and a small event status/mask pair.
  Assumes the message handler and the interface register path deliver
  one-cycle set/clear strobes on the same clock, one object per strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module cmsf_flag_bank
  import cmsf_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // handler strobes
  input  wire logic                        hdl_txrq_set,
  input  wire logic                        hdl_txrq_clr,
  input  wire logic                        hdl_ndat_set,
  input  wire logic                        hdl_ndat_clr,
  input  wire logic                        hdl_ipnd_set,
  input  wire logic                        hdl_ipnd_clr,
  input  wire logic [cmsf_pkg::OBJ_IDX_W-1:0] hdl_obj,
  // message interface write path (sets or clears)
  input  wire logic                        mif_wr,
  input  wire logic [cmsf_pkg::OBJ_IDX_W-1:0] mif_obj,
  input  wire logic                        mif_txrq_we,
  input  wire logic                        mif_txrq_val,
  input  wire logic                        mif_ndat_we,
  input  wire logic                        mif_ndat_val,
  input  wire logic                        mif_ipnd_we,
  input  wire logic                        mif_ipnd_val,
  // flag views
  output logic [cmsf_pkg::NUM_OBJ-1:0]     pending_transmit_flag,
  output logic [cmsf_pkg::NUM_OBJ-1:0]     fresh_payload_flag,
  output logic [cmsf_pkg::NUM_OBJ-1:0]     object_irq_flag,
  output logic [cmsf_pkg::OBJ_IDX_W:0]     interrupt_identifier,
  output logic                             irq
);
  import cmsf_pkg::*;

  // ==========================================================
  // flag storage
  logic [NUM_OBJ-1:0] txrq_r;
  logic [NUM_OBJ-1:0] ndat_r;
  logic [NUM_OBJ-1:0] ipnd_r;

  // per-object update; interface path wins over handler on same object
  // since software writes are explicit and arrive at most once per access
  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_obj
      logic hit_h;
      logic hit_m;
      assign hit_h = (hdl_obj == OBJ_IDX_W'(g));
      assign hit_m = mif_wr && (mif_obj == OBJ_IDX_W'(g));

      always_ff @(posedge clock) begin
        if (rst) begin
          txrq_r[g] <= 1'b0;
        end else if (hit_m && mif_txrq_we) begin
          txrq_r[g] <= mif_txrq_val;
        end else if (hit_h && hdl_txrq_set) begin
          txrq_r[g] <= 1'b1;
        end else if (hit_h && hdl_txrq_clr) begin
          txrq_r[g] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          ndat_r[g] <= 1'b0;
        end else if (hit_m && mif_ndat_we) begin
          ndat_r[g] <= mif_ndat_val;
        end else if (hit_h && hdl_ndat_set) begin
          ndat_r[g] <= 1'b1;
        end else if (hit_h && hdl_ndat_clr) begin
          ndat_r[g] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          ipnd_r[g] <= 1'b0;
        end else if (hit_m && mif_ipnd_we) begin
          ipnd_r[g] <= mif_ipnd_val;
        end else if (hit_h && hdl_ipnd_set) begin
          ipnd_r[g] <= 1'b1;
        end else if (hit_h && hdl_ipnd_clr) begin
          ipnd_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pending_transmit_flag = txrq_r;
  assign fresh_payload_flag    = ndat_r;
  assign object_irq_flag       = ipnd_r;

  // ==========================================================
  // interrupt identifier: lowest pending object number plus one, 0 when none
  logic [OBJ_IDX_W:0] irq_id_nxt;
  logic [OBJ_IDX_W:0] irq_id_r;

  always_comb begin
    irq_id_nxt = IRQ_ID_NONE;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (ipnd_r[i]) begin
        irq_id_nxt = (OBJ_IDX_W + 1)'(i + 1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_id_r <= IRQ_ID_NONE;
    end else begin
      irq_id_r <= irq_id_nxt;
    end
  end

  assign interrupt_identifier = irq_id_r;

  // ==========================================================
  // event status (rising flag edges) and mask
  logic [NUM_OBJ-1:0] txrq_d_r;
  logic [NUM_OBJ-1:0] ndat_d_r;
  logic [NUM_OBJ-1:0] ipnd_d_r;
  logic [EVT_W-1:0]   evt_raw;
  logic [EVT_W-1:0]   evt_sts_r;
  logic [EVT_W-1:0]   evt_msk_r;
  logic [EVT_W-1:0]   evt_clr;
  logic               msk_we;

  always_ff @(posedge clock) begin
    if (rst) begin
      txrq_d_r <= FLAGS_RST;
      ndat_d_r <= FLAGS_RST;
      ipnd_d_r <= FLAGS_RST;
    end else begin
      txrq_d_r <= txrq_r;
      ndat_d_r <= ndat_r;
      ipnd_d_r <= ipnd_r;
    end
  end

  assign evt_raw[EVT_TXRQ_B] = |(txrq_r & ~txrq_d_r);
  assign evt_raw[EVT_NDAT_B] = |(ndat_r & ~ndat_d_r);
  assign evt_raw[EVT_IPND_B] = |(ipnd_r & ~ipnd_d_r);

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_sts_r <= EVT_RST;
    end else begin
      evt_sts_r <= (evt_sts_r & ~evt_clr) | evt_raw;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      evt_msk_r <= EVT_RST;
    end else if (msk_we) begin
      evt_msk_r <= hwdata[EVT_W-1:0];
    end
  end

  assign irq = |(evt_sts_r & evt_msk_r);

  // ==========================================================
  // ahb-lite slave: zero wait states, always OKAY
  logic                 dp_wr_r;
  logic [ADDR_W-1:0]    dp_addr_r;
  logic                 ap_valid;
  logic [31:0]          rd_nxt;

  assign ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge clock) begin
    if (rst) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
    end else begin
      dp_wr_r   <= ap_valid && hwrite;
      dp_addr_r <= haddr[ADDR_W-1:0];
    end
  end

  // only the event registers take writes; the flag bank ignores them
  assign msk_we  = dp_wr_r && (dp_addr_r == EVT_MSK_OFS);
  assign evt_clr = (dp_wr_r && dp_addr_r == EVT_STS_OFS) ? hwdata[EVT_W-1:0] : EVT_RST;

  always_comb begin
    rd_nxt = REG_RST;
    unique case (haddr[ADDR_W-1:0])
      TXRQ_LO_OFS: rd_nxt[HALF_OBJ-1:0] = txrq_r[HALF_OBJ-1:0];
      TXRQ_HI_OFS: rd_nxt[HALF_OBJ-1:0] = txrq_r[NUM_OBJ-1:HALF_OBJ];
      NDAT_LO_OFS: rd_nxt[HALF_OBJ-1:0] = ndat_r[HALF_OBJ-1:0];
      NDAT_HI_OFS: rd_nxt[HALF_OBJ-1:0] = ndat_r[NUM_OBJ-1:HALF_OBJ];
      IPND_LO_OFS: rd_nxt[HALF_OBJ-1:0] = ipnd_r[HALF_OBJ-1:0];
      IPND_HI_OFS: rd_nxt[HALF_OBJ-1:0] = ipnd_r[NUM_OBJ-1:HALF_OBJ];
      IRQ_ID_OFS:  rd_nxt[OBJ_IDX_W:0]  = irq_id_r;
      EVT_STS_OFS: rd_nxt[EVT_W-1:0]    = evt_sts_r;
      EVT_MSK_OFS: rd_nxt[EVT_W-1:0]    = evt_msk_r;
      default:     rd_nxt = REG_RST;
    endcase
  end

  // read data registered at the address phase edge; writes never reach flags
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= REG_RST;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

endmodule
`default_nettype wire

// >>> shared/cmsf_pkg.sv
/*
  Package for the message-object status flag bank: register offsets,
  field layout, reset values and the interrupt status/mask layout.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
`default_nettype none
package cmsf_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_OBJ   = 32;
  localparam int HALF_OBJ  = 16;
  localparam int OBJ_IDX_W = 5;
  localparam int ADDR_W    = 12;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] TXRQ_LO_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] TXRQ_HI_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] NDAT_LO_OFS = 12'h120;
  localparam logic [ADDR_W-1:0] NDAT_HI_OFS = 12'h124;
  localparam logic [ADDR_W-1:0] IPND_LO_OFS = 12'h140;
  localparam logic [ADDR_W-1:0] IPND_HI_OFS = 12'h144;
  localparam logic [ADDR_W-1:0] IRQ_ID_OFS  = 12'h010;
  localparam logic [ADDR_W-1:0] EVT_STS_OFS = 12'h180;
  localparam logic [ADDR_W-1:0] EVT_MSK_OFS = 12'h184;

  // ==========================================================
  // reset values
  localparam logic [NUM_OBJ-1:0]  FLAGS_RST = 32'h00000000;
  localparam logic [31:0]         REG_RST   = 32'h00000000;
  localparam logic [2:0]          EVT_RST   = 3'h0;
  localparam logic [OBJ_IDX_W:0]  IRQ_ID_NONE = 6'h00;

  // ==========================================================
  // event status/mask bit positions
  localparam int EVT_TXRQ_B = 0;
  localparam int EVT_NDAT_B = 1;
  localparam int EVT_IPND_B = 2;
  localparam int EVT_W      = 3;

  // ==========================================================
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;
endpackage
`default_nettype wire

// >>> testbench/cmsf_flag_bank_assertions.sv
/*
  Checker for the status flag bank: bus response, flag updates and
  interrupt identifier timing. Sees only the bank's ports; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module cmsf_flag_bank_assertions
  import cmsf_pkg::*;
(
  input wire logic                            clock,
  input wire logic                            rst,
  input wire logic [31:0]                     hrdata,
  input wire logic                            hreadyout,
  input wire logic                            hresp,
  input wire logic                            hdl_txrq_set,
  input wire logic                            hdl_txrq_clr,
  input wire logic                            hdl_ipnd_set,
  input wire logic                            hdl_ipnd_clr,
  input wire logic [cmsf_pkg::OBJ_IDX_W-1:0]  hdl_obj,
  input wire logic                            mif_wr,
  input wire logic [cmsf_pkg::OBJ_IDX_W-1:0]  mif_obj,
  input wire logic                            mif_txrq_we,
  input wire logic                            mif_ndat_we,
  input wire logic                            mif_ndat_val,
  input wire logic [cmsf_pkg::NUM_OBJ-1:0]    pending_transmit_flag,
  input wire logic [cmsf_pkg::NUM_OBJ-1:0]    fresh_payload_flag,
  input wire logic [cmsf_pkg::NUM_OBJ-1:0]    object_irq_flag,
  input wire logic [cmsf_pkg::OBJ_IDX_W:0]    interrupt_identifier
);
  import cmsf_pkg::*;

  // ==========================================================
  // helper: lowest pending object number plus one, 0 when none
  logic [5:0] low_c;
  always_comb begin
    low_c = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (object_irq_flag[i]) begin
        low_c = 6'(i + 1);
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  sequence s_first_set;
    hdl_ipnd_set && hdl_obj == 5'h00 && !mif_wr;
  endsequence
  a_ready_always: assert property (hreadyout == 1'b1)
    else $error("bank inserted a wait state");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("bank answered with an error");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");
  a_txrq_set: assert property (hdl_txrq_set && !mif_wr
    |=> pending_transmit_flag[$past(hdl_obj)]) else $error("transmit flag not set by handler");
  a_txrq_hold: assert property (!hdl_txrq_set && !hdl_txrq_clr && !(mif_wr && mif_txrq_we)
    |=> $stable(pending_transmit_flag)) else $error("transmit flags moved without a strobe");
  a_ndat_sw: assert property (mif_wr && mif_ndat_we
    |=> fresh_payload_flag[$past(mif_obj)] == $past(mif_ndat_val))
    else $error("payload flag write lost");
  a_ipnd_clr: assert property (hdl_ipnd_clr && !hdl_ipnd_set && !mif_wr
    |=> !object_irq_flag[$past(hdl_obj)]) else $error("interrupt flag not cleared");
  a_id_lowest: assert property (!$past(rst) |-> interrupt_identifier == $past(low_c))
    else $error("identifier does not track lowest pending object");
  a_id_first: assert property (s_first_set |-> ##2 interrupt_identifier == 6'h01)
    else $error("identifier not one after first object set");
endmodule
bind cmsf_flag_bank cmsf_flag_bank_assertions cmsf_flag_bank_assertions_inst (
  .clock(clock), .rst(rst), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .hdl_txrq_set(hdl_txrq_set), .hdl_txrq_clr(hdl_txrq_clr), .hdl_ipnd_set(hdl_ipnd_set),
  .hdl_ipnd_clr(hdl_ipnd_clr), .hdl_obj(hdl_obj), .mif_wr(mif_wr), .mif_obj(mif_obj),
  .mif_txrq_we(mif_txrq_we), .mif_ndat_we(mif_ndat_we), .mif_ndat_val(mif_ndat_val),
  .pending_transmit_flag(pending_transmit_flag), .fresh_payload_flag(fresh_payload_flag),
  .object_irq_flag(object_irq_flag), .interrupt_identifier(interrupt_identifier));
`default_nettype wire

// >>> testbench/cmsf_flag_bank_tb.sv
/*
  Self-checking bench for the status flag bank: AHB-Lite tasks, strobe
  tasks and register checks. Assumes the single zero-wait slave.
*/
`timescale 1ns/1ps
`default_nettype none
module cmsf_flag_bank_tb;
  import cmsf_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        mif_wr = 1'b0;
  logic        irq;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  mwe = 3'h0;
  logic [2:0]  mval = 3'h0;
  logic [4:0]  obj = 5'h00;
  logic [4:0]  mobj = 5'h00;
  logic [5:0]  hs = 6'h00;
  logic [5:0]  iid;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] ptf;
  logic [31:0] fpf;
  logic [31:0] oif;
  logic [11:0] regs [4] = '{TXRQ_HI_OFS, NDAT_LO_OFS, NDAT_HI_OFS, IPND_LO_OFS};
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #12.5 clock = ~clock;
  cmsf_flag_bank cmsf_flag_bank_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hdl_txrq_set(hs[0]), .hdl_txrq_clr(hs[1]), .hdl_ndat_set(hs[2]),
    .hdl_ndat_clr(hs[3]), .hdl_ipnd_set(hs[4]), .hdl_ipnd_clr(hs[5]), .hdl_obj(obj),
    .mif_wr(mif_wr), .mif_obj(mobj), .mif_txrq_we(mwe[0]), .mif_txrq_val(mval[0]),
    .mif_ndat_we(mwe[1]), .mif_ndat_val(mval[1]), .mif_ipnd_we(mwe[2]), .mif_ipnd_val(mval[2]),
    .pending_transmit_flag(ptf), .fresh_payload_flag(fpf), .object_irq_flag(oif),
    .interrupt_identifier(iid), .irq(irq));
  // ==========================================================
  // tasks
  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // strobe, then two spare cycles so the identifier has settled
  task automatic hdl(input int k, input logic [4:0] o);
    hs <= 6'h01 << k;
    obj <= o;
    @(posedge clock);
    hs <= 6'h00;
    repeat (2) @(posedge clock);
  endtask
  task automatic sw(input logic [4:0] o, input logic [2:0] we, input logic [2:0] v);
    mif_wr <= 1'b1;
    mobj <= o;
    mwe <= we;
    mval <= v;
    @(posedge clock);
    mif_wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // ==========================================================
  // hang guard, then the test sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    foreach (regs[i]) rchk(regs[i], 32'h0, "reset value");
    hdl(0, 5'h10);
    hdl(0, 5'h1f);
    bus(1'b1, TXRQ_HI_OFS, 32'h0000_ffff);
    rchk(TXRQ_HI_OFS, 32'h0000_8001, "txrq high");
    chk("txrq flags", 32'h8001_0000, ptf);
    hdl(1, 5'h1f);
    rchk(TXRQ_HI_OFS, 32'h0000_0001, "txrq after clear");
    sw(5'h01, 3'h1, 3'h1);
    rchk(TXRQ_LO_OFS, 32'h0000_0002, "txrq low");
    hdl(2, 5'h00);
    sw(5'h1f, 3'h2, 3'h2);
    bus(1'b1, NDAT_HI_OFS, 32'h0);
    rchk(NDAT_LO_OFS, 32'h0000_0001, "ndat low");
    rchk(NDAT_HI_OFS, 32'h0000_8000, "ndat high");
    sw(5'h00, 3'h2, 3'h0);
    rchk(NDAT_LO_OFS, 32'h0, "ndat cleared");
    chk("ndat flags", 32'h8000_0000, fpf);
    bus(1'b1, EVT_MSK_OFS, 32'h4);
    hdl(4, 5'h03);
    rchk(IPND_LO_OFS, 32'h0000_0008, "ipnd low");
    chk("id", 32'h4, {26'h0, iid});
    chk("irq raised", 32'h1, {31'h0, irq});
    hdl(4, 5'h00);
    chk("id lower object", 32'h1, {26'h0, iid});
    sw(5'h00, 3'h4, 3'h0);
    chk("id after sw clear", 32'h4, {26'h0, iid});
    hdl(5, 5'h03);
    chk("id none", 32'h0, {26'h0, iid});
    hdl(4, 5'h11);
    rchk(IPND_HI_OFS, 32'h0000_0002, "ipnd high");
    chk("ipnd flags", 32'h0002_0000, oif);
    rchk(IRQ_ID_OFS, 32'h0000_0012, "id register");
    bus(1'b1, EVT_STS_OFS, 32'h7);
    hdl(2, 5'h05);
    @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk(EVT_STS_OFS, 32'h2, "event status");
    rchk(12'h200, 32'h0, "unmapped");
    give_verdict();
  end
endmodule
`default_nettype wire
